// [src/fsra_top.sv]
// status register command path of a serial flash, sampled on the system clock
`timescale 1ns/10ps
`default_nettype none
`include "fsra_cfg.svh"

// Functional notes
// - opcode 09h returns the second status byte at any time, suspend included.
// - while chip select stays low the status byte repeats for polling.
// - bit 0 of the second byte mirrors bit 0 of the first byte.
// - erase suspended flag sets on erase suspend, clears on erase resume.
// - program suspended flag sets on program suspend, clears on program resume.
// - reserved bits 1 and 7:4 of the second byte read zero.
// - volatile status bits clear to zero at reset.
// - opcode 95h returns the third status byte at any time.
// - in four-wire mode each dummy byte counts as two clocks.
// - drive field bits 3:2: 2/3, full, 1/2, 1/3; default 00.
// - third byte bits 7, 6, 1 and 0 are reserved.
// - status write 01h needs the write enable latch set beforehand.
// - status write is opcode plus one byte; any other length is dropped.
// - status write leaves status bit 0 untouched; bit 1 is written only as the page 2 lock in otp mode without volatile enable.
// - chip select rise starts a timed cycle; busy high, then latch cleared.
// - outside otp mode, status write updates protection size bits and status protect bit.
// - hardware protected mode refuses every 01h status write; the c0h third byte write still goes through.
// - otp mode without volatile enable only sets one-time bits, once each.
// - after 38h the status commands run on the four-wire sequence.
// - hardware protection holds when status protect is one and protect pin low, outside quad mode and with the pin function enabled.
// - with the write enable latch clear every status write is rejected.
module fsra_top #(
  parameter int unsigned TW_NS = `FSRA_TW_NS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic [3:0] dq_i,
  output fsra_pkg::fsra_pin_out_type dq_drv,
  input wire logic array_busy,
  input wire logic erase_suspend_evt,
  input wire logic erase_resume_evt,
  input wire logic program_suspend_evt,
  input wire logic program_resume_evt,
  input wire logic otp_mode,
  input wire logic volatile_status_en,
  output fsra_pkg::fsra_prot_type prot_o,
  output fsra_pkg::fsra_otp_type otp_o,
  output logic write_enable_latch,
  output logic busy_flag,
  output logic quad_mode,
  output logic [5:0] dummy_clocks,
  output logic [1:0] drive_strength
);
  import fsra_pkg::*;

  // cycle count of the timed write, least time rounded up
  localparam int unsigned TW_CYC_RAW = (TW_NS + `FSRA_CLK_PERIOD_NS - 1) / `FSRA_CLK_PERIOD_NS;
  localparam int unsigned TW_CYC = (TW_CYC_RAW < 1) ? 1 : TW_CYC_RAW;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  fsra_pin_in_type pin_raw;
  fsra_pin_in_type pin_s;
  assign pin_raw = '{sck: sck, cs_n: cs_n, wp_n: wp_n, dq: dq_i};

  fsra_sync #(
    .WIDTH(7),
    .RESET_VAL(`FSRA_PIN_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(pin_raw),
    .q(pin_s)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fsra_state_type state_r, state_nxt;
  logic sck_prev_r, sck_prev_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] op_r, op_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic [7:0] obyte_r, obyte_nxt;
  logic [2:0] opos_r, opos_nxt;
  logic write_enable_latch_r, write_enable_latch_nxt;
  logic quad_r, quad_nxt;
  fsra_prot_type prot_r, prot_nxt;
  fsra_otp_type otp_r, otp_nxt;
  logic erase_suspended_flag_r, erase_suspended_flag_nxt;
  logic program_suspended_flag_r, program_suspended_flag_nxt;
  logic [1:0] dummy_r, dummy_nxt;
  logic [1:0] drive_r, drive_nxt;
  logic [5:0] dclk_r, dclk_nxt;
  fsra_pin_out_type drv_r, drv_nxt;

  logic sck_rise, sck_fall;
  logic [4:0] bits_sum;
  logic [7:0] shift_in;
  logic busy_w, hw_protected, wt_start, wt_busy, wt_done;
  logic [7:0] sr1, sr2, sr3, cur_byte, out_src;
  logic [2:0] dummy_bytes;

  // edges come from the second sync stage against its own history
  assign sck_rise = pin_s.sck && !sck_prev_r;
  assign sck_fall = !pin_s.sck && sck_prev_r;
  assign bits_sum = (bits_r > `FSRA_BITS_SAT) ? `FSRA_BITS_MAX :
                    bits_r + (quad_r ? 5'h04 : 5'h01);
  // four-wire mode takes a nibble per clock, else one bit on dq0
  assign shift_in = quad_r ? {shift_r[3:0], pin_s.dq} : {shift_r[6:0], pin_s.dq[0]};

  // ----------------------------------------------------------------
  // status bytes
  // ----------------------------------------------------------------
  assign busy_w = array_busy || wt_busy;
  // protect pin has no meaning once disabled or used as a quad data line
  assign hw_protected = prot_r.status_protect_bit && !pin_s.wp_n &&
                        !otp_r.pin_function_disable && !quad_r;
  assign sr1 = otp_mode ?
    {otp_r.security_page0_lock, otp_r.pin_function_disable, 1'b0, otp_r.complement_protect,
     otp_r.boot_lock_enable, otp_r.security_page1_lock, otp_r.security_page2_lock, busy_w} :
    {prot_r, write_enable_latch_r, busy_w};
  assign sr2 = {4'h0, program_suspended_flag_r, erase_suspended_flag_r, 1'b0, busy_w};
  assign sr3 = {2'h0, dummy_r, drive_r, 2'h0};

  // byte picked by the opcode; sampled fresh at every byte boundary
  always_comb begin
    cur_byte = sr1;
    if (op_r == `FSRA_OP_READ_SECOND) begin
      cur_byte = sr2;
    end else if (op_r == `FSRA_OP_READ_THIRD) begin
      cur_byte = sr3;
    end
  end
  assign out_src = (opos_r == 3'h0) ? cur_byte : obyte_r;

  // dummy byte count from the field code
  always_comb begin
    unique case (dummy_r)
      2'b00: dummy_bytes = `FSRA_DUMMY_CODE_00;
      2'b01: dummy_bytes = `FSRA_DUMMY_CODE_01;
      2'b10: dummy_bytes = `FSRA_DUMMY_CODE_10;
      2'b11: dummy_bytes = `FSRA_DUMMY_CODE_11;
    endcase
  end

  // ----------------------------------------------------------------
  // timed write cycle
  // ----------------------------------------------------------------
  fsra_wtimer #(
    .CYCLES(TW_CYC)
  ) u_wtimer (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(wt_start),
    .busy(wt_busy),
    .done(wt_done)
  );

  // ----------------------------------------------------------------
  // frame decoder, status bits and output shifter
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    sck_prev_nxt = pin_s.sck;
    bits_nxt = bits_r;
    shift_nxt = shift_r;
    op_nxt = op_r;
    pend_nxt = pend_r;
    obyte_nxt = obyte_r;
    opos_nxt = opos_r;
    write_enable_latch_nxt = write_enable_latch_r;
    quad_nxt = quad_r;
    prot_nxt = prot_r;
    otp_nxt = otp_r;
    erase_suspended_flag_nxt = erase_suspended_flag_r;
    program_suspended_flag_nxt = program_suspended_flag_r;
    dummy_nxt = dummy_r;
    drive_nxt = drive_r;
    drv_nxt = drv_r;
    wt_start = 1'b0;
    // quad quadruples the byte rate, so twice per byte instead of eight
    dclk_nxt = quad_r ? {2'h0, dummy_bytes, 1'b0} : {dummy_bytes, 3'h0};

    // resume clears, a suspend in the same cycle still wins
    if (erase_resume_evt) begin
      erase_suspended_flag_nxt = 1'b0;
    end
    if (erase_suspend_evt) begin
      erase_suspended_flag_nxt = 1'b1;
    end
    if (program_resume_evt) begin
      program_suspended_flag_nxt = 1'b0;
    end
    if (program_suspend_evt) begin
      program_suspended_flag_nxt = 1'b1;
    end

    unique case (state_r)
      ST_IDLE: begin
        if (!pin_s.cs_n) begin
          state_nxt = ST_OPC;
          bits_nxt = 5'h00;
        end
      end
      ST_OPC, ST_DATA: begin
        if (pin_s.cs_n) begin
          state_nxt = ST_IDLE;
          // one-byte commands act only on an exact opcode frame
          if (state_r == ST_DATA && bits_r == `FSRA_BITS_OPCODE && !busy_w) begin
            if (op_r == `FSRA_OP_WRITE_ENABLE) begin
              write_enable_latch_nxt = 1'b1;
            end
            if (op_r == `FSRA_OP_WRITE_DISABLE) begin
              write_enable_latch_nxt = 1'b0;
            end
            if (op_r == `FSRA_OP_ENTER_QUAD) begin
              quad_nxt = 1'b1;
            end
            if (op_r == `FSRA_OP_EXIT_QUAD) begin
              quad_nxt = 1'b0;
            end
          end
          // writes need exactly opcode plus one byte and the latch set
          if (state_r == ST_DATA && bits_r == `FSRA_BITS_WITH_DATA &&
              write_enable_latch_r && !busy_w) begin
            if (op_r == `FSRA_OP_WRITE_STATUS && !hw_protected) begin
              wt_start = 1'b1;
              pend_nxt = shift_r;
            end
            if (op_r == `FSRA_OP_WRITE_THIRD) begin
              dummy_nxt = shift_r[5:4];
              drive_nxt = shift_r[3:2];
              write_enable_latch_nxt = 1'b0;
            end
          end
        end else if (sck_rise) begin
          shift_nxt = shift_in;
          bits_nxt = bits_sum;
          if (state_r == ST_OPC && bits_sum == `FSRA_BITS_OPCODE) begin
            op_nxt = shift_in;
            opos_nxt = 3'h0;
            if (shift_in == `FSRA_OP_READ_FIRST || shift_in == `FSRA_OP_READ_SECOND ||
                shift_in == `FSRA_OP_READ_THIRD) begin
              state_nxt = ST_READ;
            end else begin
              state_nxt = ST_DATA;
            end
          end
        end
      end
      ST_READ: begin
        if (pin_s.cs_n) begin
          state_nxt = ST_IDLE;
          drv_nxt = '{dq_o: 4'h0, dq_oe_n: `FSRA_DQ_RELEASED};
        end else if (sck_fall) begin
          // msb first; the byte repeats for as long as the frame lasts
          if (quad_r) begin
            drv_nxt = '{dq_o: out_src[7:4], dq_oe_n: `FSRA_DQ_QUAD_OUT};
            obyte_nxt = {out_src[3:0], 4'h0};
            opos_nxt = opos_r + 3'h4;
          end else begin
            drv_nxt = '{dq_o: {2'h0, out_src[7], 1'b0}, dq_oe_n: `FSRA_DQ_SINGLE_OUT};
            obyte_nxt = {out_src[6:0], 1'b0};
            opos_nxt = opos_r + 3'h1;
          end
        end
      end
    endcase

    // end of the timed cycle commits the byte; bit 0 never comes from it, bit 1 only as the one-time page 2 lock
    if (wt_done) begin
      if (otp_mode && !volatile_status_en) begin
        // one-time bits can only go from zero to one
        otp_nxt.security_page0_lock = otp_r.security_page0_lock | pend_r[7];
        otp_nxt.pin_function_disable = otp_r.pin_function_disable | pend_r[6];
        otp_nxt.complement_protect = otp_r.complement_protect | pend_r[4];
        otp_nxt.boot_lock_enable = otp_r.boot_lock_enable | pend_r[3];
        otp_nxt.security_page1_lock = otp_r.security_page1_lock | pend_r[2];
        otp_nxt.security_page2_lock = otp_r.security_page2_lock | pend_r[1];
      end else if (otp_mode) begin
        otp_nxt.pin_function_disable = pend_r[6];
        otp_nxt.complement_protect = pend_r[4];
        otp_nxt.boot_lock_enable = pend_r[3];
      end else begin
        prot_nxt = fsra_prot_type'(pend_r[7:2]);
      end
      write_enable_latch_nxt = 1'b0;
    end
  end

  // every volatile bit returns to zero on reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      sck_prev_r <= 1'b0;
      bits_r <= 5'h00;
      shift_r <= 8'h00;
      op_r <= 8'h00;
      pend_r <= 8'h00;
      obyte_r <= 8'h00;
      opos_r <= 3'h0;
      write_enable_latch_r <= 1'b0;
      quad_r <= 1'b0;
      prot_r <= '0;
      otp_r <= '0;
      erase_suspended_flag_r <= 1'b0;
      program_suspended_flag_r <= 1'b0;
      dummy_r <= `FSRA_DUMMY_RESET;
      drive_r <= `FSRA_DRIVE_RESET;
      dclk_r <= 6'h00;
      drv_r <= '{dq_o: 4'h0, dq_oe_n: `FSRA_DQ_RELEASED};
    end else begin
      state_r <= state_nxt;
      sck_prev_r <= sck_prev_nxt;
      bits_r <= bits_nxt;
      shift_r <= shift_nxt;
      op_r <= op_nxt;
      pend_r <= pend_nxt;
      obyte_r <= obyte_nxt;
      opos_r <= opos_nxt;
      write_enable_latch_r <= write_enable_latch_nxt;
      quad_r <= quad_nxt;
      prot_r <= prot_nxt;
      otp_r <= otp_nxt;
      erase_suspended_flag_r <= erase_suspended_flag_nxt;
      program_suspended_flag_r <= program_suspended_flag_nxt;
      dummy_r <= dummy_nxt;
      drive_r <= drive_nxt;
      dclk_r <= dclk_nxt;
      drv_r <= drv_nxt;
    end
  end

  // outputs
  assign dq_drv = drv_r;
  assign prot_o = prot_r;
  assign otp_o = otp_r;
  assign write_enable_latch = write_enable_latch_r;
  assign busy_flag = busy_w;
  assign quad_mode = quad_r;
  assign dummy_clocks = dclk_r;
  assign drive_strength = drive_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence sq_rd2_opcode;
    state_r == ST_OPC && !pin_s.cs_n && sck_rise && bits_sum == `FSRA_BITS_OPCODE &&
      shift_in == `FSRA_OP_READ_SECOND;
  endsequence

  sequence sq_wr_launch;
    state_r == ST_DATA && pin_s.cs_n && wt_start;
  endsequence

  rd2_accept_a: assert property (@(posedge clk_sys) disable iff (srst)
    sq_rd2_opcode |=> state_r == ST_READ && opos_r == 3'h0)
    else $error("second status read opcode not accepted");

  poll_repeat_a: assert property (@(posedge clk_sys) disable iff (srst)
    state_r == ST_READ && !pin_s.cs_n |=> state_r == ST_READ)
    else $error("status output stopped while selected");

  busy_mirror_a: assert property (@(posedge clk_sys) disable iff (srst)
    sr2[0] == sr1[0] && sr2[0] == busy_flag)
    else $error("busy bit differs between status bytes");

  sr2_reserved_a: assert property (@(posedge clk_sys) disable iff (srst)
    sr2[7:4] == 4'h0 && sr2[1] == 1'b0 && sr3[7:6] == 2'h0 && sr3[1:0] == 2'h0)
    else $error("reserved status bit not zero");

  erase_susp_a: assert property (@(posedge clk_sys) disable iff (srst)
    (erase_suspend_evt |=> erase_suspended_flag_r) and
    (erase_resume_evt && !erase_suspend_evt |=> !erase_suspended_flag_r))
    else $error("erase suspended flag wrong after event");

  prog_susp_a: assert property (@(posedge clk_sys) disable iff (srst)
    (program_suspend_evt |=> program_suspended_flag_r) and
    (program_resume_evt && !program_suspend_evt |=> !program_suspended_flag_r))
    else $error("program suspended flag wrong after event");

  dummy_quad_a: assert property (@(posedge clk_sys) disable iff (srst)
    quad_r && dummy_r == 2'b11 |=> dummy_clocks == 6'h0a)
    else $error("quad dummy clock count wrong");

  wr_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    wt_start |-> write_enable_latch_r && !hw_protected && bits_r == `FSRA_BITS_WITH_DATA)
    else $error("status write launched without permission");

  wr_cycle_a: assert property (@(posedge clk_sys) disable iff (srst)
    sq_wr_launch |=> busy_flag && state_r == ST_IDLE)
    else $error("timed write cycle did not raise busy");

  wr_finish_a: assert property (@(posedge clk_sys) disable iff (srst)
    wt_done |=> !write_enable_latch_r && !wt_busy)
    else $error("latch not cleared at end of write cycle");

  wr_commit_a: assert property (@(posedge clk_sys) disable iff (srst)
    wt_done && !otp_mode |=> prot_r == $past(pend_r[7:2]) ##1 $stable(prot_r))
    else $error("protection bits not committed");

  otp_once_a: assert property (@(posedge clk_sys) disable iff (srst)
    otp_r.security_page0_lock |=> otp_r.security_page0_lock)
    else $error("one-time lock bit was cleared");
endmodule : fsra_top

`default_nettype wire

// [src/fsra_cfg.svh]
// constants of the flash status register access block
`ifndef FSRA_CFG_SVH
`define FSRA_CFG_SVH

// opcodes taken by the status path
`define FSRA_OP_WRITE_STATUS 8'h01
`define FSRA_OP_WRITE_DISABLE 8'h04
`define FSRA_OP_READ_FIRST 8'h05
`define FSRA_OP_WRITE_ENABLE 8'h06
`define FSRA_OP_READ_SECOND 8'h09
`define FSRA_OP_READ_THIRD 8'h95
`define FSRA_OP_ENTER_QUAD 8'h38
`define FSRA_OP_EXIT_QUAD 8'hff
`define FSRA_OP_WRITE_THIRD 8'hc0

// frame lengths in link bits
`define FSRA_BITS_OPCODE 5'h08
`define FSRA_BITS_WITH_DATA 5'h10
`define FSRA_BITS_SAT 5'h1b
`define FSRA_BITS_MAX 5'h1f

// timing
`define FSRA_CLK_PERIOD_NS 50
`define FSRA_TW_NS 5000000

// reset values
`define FSRA_PIN_RESET 7'h30
`define FSRA_DUMMY_RESET 2'h0
`define FSRA_DRIVE_RESET 2'h0
`define FSRA_DQ_RELEASED 4'hf
`define FSRA_DQ_SINGLE_OUT 4'hd
`define FSRA_DQ_QUAD_OUT 4'h0

// dummy byte counts per field code
`define FSRA_DUMMY_CODE_00 3'h3
`define FSRA_DUMMY_CODE_01 3'h2
`define FSRA_DUMMY_CODE_10 3'h4
`define FSRA_DUMMY_CODE_11 3'h5

`endif

// [src/fsra_pkg.sv]
// types of the flash status register access block
package fsra_pkg;

  // link frame states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC = 2'b01,
    ST_DATA = 2'b10,
    ST_READ = 2'b11
  } fsra_state_type;

  // pins sampled from the link
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic wp_n;
    logic [3:0] dq;
  } fsra_pin_in_type;

  // data pin drive, enable low drives
  typedef struct packed {
    logic [3:0] dq_o;
    logic [3:0] dq_oe_n;
  } fsra_pin_out_type;

  // protection bits, ordered as data bits 7:2 of a normal status write
  typedef struct packed {
    logic status_protect_bit;
    logic boot_lock_granularity;
    logic top_bottom_select;
    logic block_protect_hi;
    logic block_protect_mid;
    logic block_protect_lo;
  } fsra_prot_type;

  // one-time bits of the otp layout
  typedef struct packed {
    logic security_page0_lock;
    logic pin_function_disable;
    logic complement_protect;
    logic boot_lock_enable;
    logic security_page1_lock;
    logic security_page2_lock;
  } fsra_otp_type;

endpackage : fsra_pkg

// [src/fsra_sync.sv]
// two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none

module fsra_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r, meta_nxt;
  logic [WIDTH-1:0] hold_r, hold_nxt;

  // first stage feeds the second only
  always_comb begin
    meta_nxt = d;
    hold_nxt = meta_r;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= RESET_VAL;
      hold_r <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign q = hold_r;
endmodule : fsra_sync

`default_nettype wire

// [src/fsra_wtimer.sv]
// self-timed cycle counter for the status write
`timescale 1ns/10ps
`default_nettype none

module fsra_wtimer #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [31:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;

  // load on start, count down, finish on the last busy cycle
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    if (busy_r) begin
      if (cnt_r == 32'h1) begin
        busy_nxt = 1'b0;
        cnt_nxt = 32'h0;
      end else begin
        cnt_nxt = cnt_r - 32'h1;
      end
    end else if (start) begin
      busy_nxt = 1'b1;
      cnt_nxt = CYCLES[31:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
  assign done = busy_r && (cnt_r == 32'h1);

  tw_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    start && !busy_r |=> busy_r && cnt_r == CYCLES[31:0])
    else $error("cycle timer did not load its length");
endmodule : fsra_wtimer

`default_nettype wire

// [verif/fsra_host.sv]
// host side model of the serial status link
`timescale 1ns/10ps
`default_nettype none
module fsra_host (
  input wire logic clk_sys,
  input wire fsra_pkg::fsra_pin_out_type dq_drv,
  output var logic sck,
  output var logic cs_n,
  output wire logic [3:0] dq_i
);
  import fsra_pkg::*;
  logic [3:0] hd = 4'h0;
  // wire level: the device wins wherever it drives
  assign dq_i = (dq_drv.dq_oe_n & hd) | (~dq_drv.dq_oe_n & dq_drv.dq_o);
  // clock idles low, so it stands still between frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  // one frame: opcode, nb bytes, read bits gathered msb first
  task automatic xfer(input logic q, input logic [7:0] op, input logic [15:0] wd,
    input int nb, output logic [15:0] rd);
    logic [23:0] sh;
    int w;
    w = q ? 4 : 1;
    sh = {op, wd};
    rd = '0;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 8 * (nb + 1) / w; i++) begin
      sck <= 1'b0;
      hd <= q ? sh[23:20] : {3'h0, sh[23]};
      sh = sh << w;
      repeat (4) @(posedge clk_sys);
      sck <= 1'b1;
      repeat (2) @(posedge clk_sys);
      // sampled mid high level, well clear of the next shift
      if (i >= 8 / w)
        rd = q ? {rd[11:0], dq_i} : {rd[14:0], dq_i[1]};
      repeat (2) @(posedge clk_sys);
    end
    sck <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    hd <= ~hd; // released line must not keep its old value
    repeat (6) @(posedge clk_sys);
  endtask : xfer
endmodule : fsra_host
`default_nettype wire

// [verif/tb_fsra_top.sv]
// self-checking bench of the status register path
`timescale 1ns/10ps
`default_nettype none
module tb_fsra_top;
  import fsra_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic wp_n = 1'b1;
  logic array_busy = 1'b0;
  logic otp_mode = 1'b0;
  logic vse = 1'b0;
  logic [3:0] ev = 4'h0;
  logic sck, cs_n, latch, busy, quad;
  wire [3:0] dq_i;
  logic [5:0] dclk;
  logic [1:0] drv;
  logic [15:0] rd;
  fsra_pin_out_type dq_drv;
  fsra_prot_type prot;
  fsra_otp_type otp;
  int mismatches = 0;
  int n_tests = 0;
  int nbytes[4] = '{3, 2, 4, 5};
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  // short self-timed cycle: 200 clocks
  fsra_top #(.TW_NS(10000)) fsra_top_inst (.clk_sys(clk_sys), .srst(srst), .sck(sck),
    .cs_n(cs_n), .wp_n(wp_n), .dq_i(dq_i), .dq_drv(dq_drv), .array_busy(array_busy),
    .erase_suspend_evt(ev[3]), .erase_resume_evt(ev[2]), .program_suspend_evt(ev[1]),
    .program_resume_evt(ev[0]), .otp_mode(otp_mode), .volatile_status_en(vse),
    .prot_o(prot), .otp_o(otp), .write_enable_latch(latch), .busy_flag(busy),
    .quad_mode(quad), .dummy_clocks(dclk), .drive_strength(drv));
  fsra_host fsra_host_inst (.clk_sys(clk_sys), .dq_drv(dq_drv), .sck(sck), .cs_n(cs_n),
    .dq_i(dq_i));
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic q, input logic [7:0] c, input logic [7:0] d, input int nb);
    fsra_host_inst.xfer(q, c, {d, 8'h00}, nb, rd);
  endtask : op
  // polls busy with a bound, as a careful host would
  task automatic idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_sys);
    chk(16'(busy), 16'h0);
  endtask : idle
  // enable, write, then wait out the timed cycle
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    op(quad, 8'h06, 8'h00, 0);
    op(quad, c, d, 1);
    idle();
  endtask : wr
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clk_sys);
    ev <= 4'h0;
    @(posedge clk_sys);
  endtask : pulse
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // watchdog, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
  // test sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    op(1'b0, 8'h09, 8'h00, 2);
    chk(rd, 16'h0000);
    op(1'b0, 8'h95, 8'h00, 1);
    chk(rd, 16'h0000);
    chk(16'(dclk), 16'h0018);
    $display("test reset done");
    array_busy <= 1'b1;
    pulse(4'b1000);
    op(1'b0, 8'h09, 8'h00, 2);
    chk(rd, 16'h0505);
    pulse(4'b0010);
    op(1'b0, 8'h09, 8'h00, 1);
    chk(rd, 16'h000d);
    // enable while the array is busy must be ignored
    op(1'b0, 8'h06, 8'h00, 0);
    chk(16'(latch), 16'h0);
    array_busy <= 1'b0;
    pulse(4'b0101);
    op(1'b0, 8'h09, 8'h00, 1);
    chk(rd, 16'h0000);
    // suspend and resume in one cycle: the suspend wins
    pulse(4'b1100);
    op(1'b0, 8'h09, 8'h00, 1);
    chk(rd, 16'h0004);
    pulse(4'b0100);
    $display("test suspend done");
    op(1'b0, 8'h01, 8'hfc, 1);
    idle();
    chk(16'(prot), 16'h0);
    op(1'b0, 8'h06, 8'h00, 0);
    chk(16'(latch), 16'h1);
    op(1'b0, 8'h01, 8'hff, 1);
    chk(16'(busy), 16'h1);
    op(1'b0, 8'h09, 8'h00, 1);
    chk(rd, 16'h0001);
    idle();
    chk(16'(prot), 16'h3f);
    chk(16'(latch), 16'h0);
    op(1'b0, 8'h05, 8'h00, 1);
    chk(rd, 16'h00fc);
    op(1'b0, 8'h06, 8'h00, 0);
    op(1'b0, 8'h04, 8'h00, 0);
    chk(16'(latch), 16'h0);
    $display("test write done");
    wp_n <= 1'b0;
    wr(8'h01, 8'h00);
    chk(16'(prot), 16'h3f);
    wp_n <= 1'b1;
    wr(8'h01, 8'h00);
    chk(16'(prot), 16'h0);
    op(1'b0, 8'h06, 8'h00, 0);
    op(1'b0, 8'h01, 8'hff, 2);
    idle();
    chk(16'(prot), 16'h0);
    $display("test protect done");
    for (int k = 0; k < 4; k++) begin
      wr(8'hc0, 8'(k * 20)); // no fast read follows, so any dummy code is safe
      op(1'b0, 8'h95, 8'h00, 1);
      chk(rd, 16'(k * 20));
      chk(16'(dclk), 16'(nbytes[k] * 8));
      chk(16'(drv), 16'(k));
    end
    $display("test config done");
    op(1'b0, 8'h38, 8'h00, 0);
    chk(16'(quad), 16'h1);
    op(1'b1, 8'h95, 8'h00, 1);
    chk(rd, 16'h003c);
    chk(16'(dclk), 16'h000a);
    wr(8'h01, 8'h0c);
    chk(16'(prot), 16'h03);
    op(1'b1, 8'hff, 8'h00, 0);
    chk(16'(quad), 16'h0);
    $display("test quad done");
    otp_mode <= 1'b1;
    wr(8'h01, 8'hdc);
    chk(16'(otp), 16'h3e);
    op(1'b0, 8'h05, 8'h00, 1);
    chk(rd, 16'h00dc);
    wr(8'h01, 8'h00);
    chk(16'(otp), 16'h3e);
    // with the volatile enable the three shared bits follow the data
    vse <= 1'b1;
    wr(8'h01, 8'h00);
    chk(16'(otp), 16'h22);
    $display("test otp done");
    end_sim();
  end
endmodule : tb_fsra_top
`default_nettype wire
